// *** include/plcs_cfg.svh ***
// constants for the loop clock synthesiser control block
`ifndef PLCS_CFG_SVH
`define PLCS_CFG_SVH
`define PLCS_DIV_W        8
`define PLCS_THIRD_DIV    2'h3
`define PLCS_LOCK_CYC     16'h0040
`define PLCS_DIV_RST      8'h01
`endif

// *** include/plcs_pkg.sv ***
// types for the loop clock synthesiser control block
package plcs_pkg;
	typedef struct packed {
		logic [7:0] ref_div;    // input divider ratio, 0/1 = bypass
		logic [7:0] fb_div;     // feedback divider ratio
		logic [7:0] post_div;   // post-scaler ratio
		logic [7:0] sec_div;    // secondary divider ratio
	} plcs_div_cfg_t;
	typedef struct packed {
		logic [3:0] dyn_phase_adjust;
		logic [3:0] dyn_duty_select;
		logic       fine_delay_adjust;
	} plcs_dyn_t;
	typedef enum logic [1:0] {
		PLCS_RESET,
		PLCS_ACQUIRE,
		PLCS_LOCKED
	} plcs_state_t;
endpackage : plcs_pkg

// *** hw/plcs_core.sv ***
// digital model of loop clock synthesis: dividers, lock tracking, shifted output
`timescale 1ns/100ps
`include "plcs_cfg.svh"

module plcs_core
	import plcs_pkg::*;
(
	input  wire logic          i_sys_clk,
	input  wire logic          i_rst_b,
	input  wire logic          i_ref_clk_pin,
	input  wire logic          i_ref_clk_fabric,
	input  wire logic          i_ref_sel_fabric,
	input  wire logic          i_feedback_clk_in,
	input  wire logic          i_fb_sel_user,
	input  wire logic          i_osc_clk,
	input  wire logic          i_main_reset,
	input  wire logic          i_sec_divider_reset,
	input  wire plcs_div_cfg_t i_div_cfg,
	input  wire logic          i_dyn_mode,
	input  wire plcs_dyn_t     i_static_adj,
	input  wire plcs_dyn_t     i_dyn_adj,
	output logic               o_primary_clk_out,
	output logic               o_shifted_clk_out,
	output logic               o_divided_clk_out,
	output logic               o_third_rate_clk_out,
	output logic               o_lock,
	output logic               o_ref_div_tick,
	output logic               o_fb_div_tick
);
	localparam int W = `PLCS_DIV_W;

	// one divider step: count to ratio-1, tick on wrap; ratio 0 acts as 1
	function automatic logic [W:0] div_step(input logic [W-1:0] cnt,
		input logic [W-1:0] ratio);
		logic [W-1:0] lim;
		lim = (ratio == '0) ? '0 : ratio - `PLCS_DIV_RST;
		if (cnt >= lim)
			div_step = {1'b1, {W{1'b0}}};
		else
			div_step = {1'b0, cnt + `PLCS_DIV_RST};
	endfunction : div_step

	logic [W-1:0] ref_cnt_q, ref_cnt_d, fb_cnt_q, fb_cnt_d;
	logic [W-1:0] post_cnt_q, post_cnt_d, sec_cnt_q, sec_cnt_d;
	logic [1:0]   third_cnt_q, third_cnt_d;
	logic [3:0]   ph_cnt_q, ph_cnt_d;
	logic [15:0]  lock_cnt_q, lock_cnt_d;
	logic         ref_prev_q, ref_prev_d, fb_prev_q, fb_prev_d, osc_prev_q, osc_prev_d;
	logic         prim_q, prim_d, shift_q, shift_d, div_q, div_d, third_q, third_d;
	logic         lock_q, lock_d, ref_tick_q, ref_tick_d, fb_tick_q, fb_tick_d;
	logic         ref_tick_pend_q, ref_tick_pend_d;
	plcs_state_t  st_q, st_d;

	logic         ref_src, fb_src, ref_rise, fb_rise, osc_rise, post_tick;
	logic [W:0]   ref_s, fb_s, post_s, sec_s;
	plcs_dyn_t    adj;

	always_comb begin
		ref_src  = i_ref_sel_fabric ? i_ref_clk_fabric : i_ref_clk_pin;
		fb_src   = i_fb_sel_user ? i_feedback_clk_in : prim_q;
		ref_rise = ref_src & ~ref_prev_q;
		fb_rise  = fb_src & ~fb_prev_q;
		osc_rise = i_osc_clk & ~osc_prev_q;
		adj      = i_dyn_mode ? i_dyn_adj : i_static_adj;
		ref_s    = div_step(ref_cnt_q, i_div_cfg.ref_div);
		fb_s     = div_step(fb_cnt_q, i_div_cfg.fb_div);
		post_s   = div_step(post_cnt_q, i_div_cfg.post_div);
		sec_s    = div_step(sec_cnt_q, i_div_cfg.sec_div);
		// post-scaler stands still in main reset, so divided holds; third moves at most once, as primary is forced low
		post_tick = osc_rise & post_s[W] & ~i_main_reset;
	end

	// dividers and output clocks; main reset holds the loop side only
	always_comb begin
		ref_prev_d  = ref_src;
		fb_prev_d   = fb_src;
		osc_prev_d  = i_osc_clk;
		ref_cnt_d   = ref_cnt_q;
		fb_cnt_d    = fb_cnt_q;
		post_cnt_d  = post_cnt_q;
		sec_cnt_d   = sec_cnt_q;
		third_cnt_d = third_cnt_q;
		ph_cnt_d    = ph_cnt_q;
		prim_d      = prim_q;
		shift_d     = shift_q;
		div_d       = div_q;
		third_d     = third_q;
		ref_tick_d  = 1'b0;
		fb_tick_d   = 1'b0;
		if (i_main_reset) begin
			ref_cnt_d  = '0;
			fb_cnt_d   = '0;
			post_cnt_d = '0;
			ph_cnt_d   = '0;
			prim_d     = 1'b0;
			shift_d    = 1'b0;
		end else begin
			if (ref_rise) begin
				ref_cnt_d  = ref_s[W-1:0];
				ref_tick_d = ref_s[W];
			end
			if (fb_rise) begin
				fb_cnt_d  = fb_s[W-1:0];
				fb_tick_d = fb_s[W];
			end
			if (osc_rise) begin
				post_cnt_d = post_s[W-1:0];
				ph_cnt_d   = ph_cnt_q + 4'h1;
			end
			// trim: the toggle is taken straight off the post-scaler, no phase offset
			if (post_tick) begin
				prim_d = ~prim_q;
				// phase count spans a whole primary period so the shifted copy
				// keeps the primary rate; phase+duty must stay below 2*post ratio
				if (!prim_q)
					ph_cnt_d = 4'h0;
			end
			// shifted copy: rises at phase count xor fine delay, falls duty steps after phase count
			if (osc_rise && ph_cnt_q == (adj.dyn_phase_adjust ^ {3'h0, adj.fine_delay_adjust}))
				shift_d = 1'b1;
			if (osc_rise && ph_cnt_q == adj.dyn_phase_adjust + adj.dyn_duty_select)
				shift_d = 1'b0;
		end
		// divided output: only its own reset clears it
		if (i_sec_divider_reset) begin
			sec_cnt_d = '0;
			div_d     = 1'b0;
		end else if (post_tick) begin
			sec_cnt_d = sec_s[W-1:0];
			if (sec_s[W])
				div_d = ~div_q;
		end
		// third rate follows primary edges, both edges counted for a /3 period
		if (prim_d != prim_q) begin
			third_cnt_d = (third_cnt_q == `PLCS_THIRD_DIV - 2'h1) ? 2'h0 : third_cnt_q + 2'h1;
			if (third_cnt_q == `PLCS_THIRD_DIV - 2'h1)
				third_d = ~third_q;
		end
	end

	// lock: reference and feedback ticks must alternate for a run of cycles
	always_comb begin
		st_d            = st_q;
		lock_cnt_d      = lock_cnt_q;
		ref_tick_pend_d = ref_tick_pend_q;
		lock_d          = 1'b0;
		unique case (st_q)
			PLCS_RESET: begin
				lock_cnt_d      = '0;
				ref_tick_pend_d = 1'b0;
				if (!i_main_reset)
					st_d = PLCS_ACQUIRE;
			end
			PLCS_ACQUIRE, PLCS_LOCKED: begin
				// a tick from one side twice without the other means drift
				if ((ref_tick_q && ref_tick_pend_q) || (fb_tick_q && !ref_tick_pend_q
					&& !ref_tick_q)) begin
					lock_cnt_d = '0;
					st_d       = PLCS_ACQUIRE;
				end else if (fb_tick_q) begin
					if (lock_cnt_q != `PLCS_LOCK_CYC)
						lock_cnt_d = lock_cnt_q + 16'h0001;
					if (lock_cnt_q == `PLCS_LOCK_CYC)
						st_d = PLCS_LOCKED;
				end
				if (ref_tick_q != fb_tick_q)
					ref_tick_pend_d = ref_tick_q;
				lock_d = (st_d == PLCS_LOCKED);
			end
		endcase
		if (i_main_reset) begin
			st_d   = PLCS_RESET;
			lock_d = 1'b0;
		end
	end

	// divider and output clock registers; previous-sample flops idle low like the pins
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ref_cnt_q   <= '0;
			fb_cnt_q    <= '0;
			post_cnt_q  <= '0;
			sec_cnt_q   <= '0;
			third_cnt_q <= 2'h0;
			ph_cnt_q    <= 4'h0;
			ref_prev_q  <= 1'b0;
			fb_prev_q   <= 1'b0;
			osc_prev_q  <= 1'b0;
			prim_q      <= 1'b0;
			shift_q     <= 1'b0;
			div_q       <= 1'b0;
			third_q     <= 1'b0;
			ref_tick_q  <= 1'b0;
			fb_tick_q   <= 1'b0;
		end else begin
			ref_cnt_q   <= ref_cnt_d;
			fb_cnt_q    <= fb_cnt_d;
			post_cnt_q  <= post_cnt_d;
			sec_cnt_q   <= sec_cnt_d;
			third_cnt_q <= third_cnt_d;
			ph_cnt_q    <= ph_cnt_d;
			ref_prev_q  <= ref_prev_d;
			fb_prev_q   <= fb_prev_d;
			osc_prev_q  <= osc_prev_d;
			prim_q      <= prim_d;
			shift_q     <= shift_d;
			div_q       <= div_d;
			third_q     <= third_d;
			ref_tick_q  <= ref_tick_d;
			fb_tick_q   <= fb_tick_d;
		end
	end

	// lock tracking registers
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lock_cnt_q      <= 16'h0000;
			lock_q          <= 1'b0;
			ref_tick_pend_q <= 1'b0;
			st_q            <= PLCS_RESET;
		end else begin
			lock_cnt_q      <= lock_cnt_d;
			lock_q          <= lock_d;
			ref_tick_pend_q <= ref_tick_pend_d;
			st_q            <= st_d;
		end
	end

	// all generated clocks leave straight from flops
	assign o_primary_clk_out    = prim_q;
	assign o_shifted_clk_out    = shift_q;
	assign o_divided_clk_out    = div_q;
	assign o_third_rate_clk_out = third_q;
	assign o_lock               = lock_q;
	assign o_ref_div_tick       = ref_tick_q;
	assign o_fb_div_tick        = fb_tick_q;
endmodule : plcs_core

// *** tb/plcs_fabric_model.sv ***
// fabric-side model: reference, feedback and oscillator levels, adjust values
`timescale 1ns/100ps
module plcs_fabric_model
	import plcs_pkg::*;
(
	input  wire logic      i_sys_clk,
	input  wire logic      i_fb_run,
	input  wire plcs_dyn_t i_dyn_req,
	output logic           o_ref_clk,
	output logic           o_fb_clk,
	output logic           o_osc_clk,
	output plcs_dyn_t      o_dyn_adj
);
	logic [2:0] ph_q = 3'h0;
	logic [2:0] lag;
	logic       fb_q = 1'b0;
	plcs_dyn_t  dyn_q = '0;
	// ref period 8, fb lags 3 so ticks interleave; a stalled fb stands low
	always_ff @(posedge i_sys_clk) begin
		ph_q  <= ph_q + 3'h1;
		fb_q  <= i_fb_run & lag[2];
		dyn_q <= i_dyn_req;
	end
	assign lag       = ph_q - 3'h2;
	assign o_ref_clk = ph_q[2];
	assign o_osc_clk = ph_q[0];
	assign o_fb_clk  = fb_q;
	assign o_dyn_adj = dyn_q;
endmodule : plcs_fabric_model

// *** tb/plcs_core_assertions.sv ***
// port checker for the loop clock synthesiser control block
`timescale 1ns/100ps
module plcs_core_assertions (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_main_reset,
	input wire logic i_sec_divider_reset,
	input wire logic o_primary_clk_out,
	input wire logic o_shifted_clk_out,
	input wire logic o_divided_clk_out,
	input wire logic o_third_rate_clk_out,
	input wire logic o_lock,
	input wire logic o_ref_div_tick
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	chk_lock_in_reset: assert property (i_main_reset |=> !o_lock)
		else $error("lock high in main reset");
	chk_lock_no_early: assert property ($fell(i_main_reset) |-> !o_lock [*8])
		else $error("lock rose too soon");
	chk_primary_held: assert property (i_main_reset |=> !o_primary_clk_out)
		else $error("primary running in main reset");
	chk_shifted_held: assert property (i_main_reset |=> !o_shifted_clk_out)
		else $error("shifted running in main reset");
	chk_sec_clear: assert property (i_sec_divider_reset |=> !o_divided_clk_out)
		else $error("divided not cleared");
	chk_third_follow: assert property ($changed(o_third_rate_clk_out)
		&& !$past(i_main_reset) |-> $changed(o_primary_clk_out))
		else $error("third moved alone");
	chk_divided_follow: assert property ($changed(o_divided_clk_out)
		&& !$past(i_sec_divider_reset) |-> $changed(o_primary_clk_out))
		else $error("divided moved alone");
	chk_ref_pulse: assert property (o_ref_div_tick |=> !o_ref_div_tick)
		else $error("ref tick too long");
	cov_lock: cover property ($rose(o_lock));
	cov_third: cover property ($changed(o_third_rate_clk_out));
	cov_shift: cover property ($rose(o_shifted_clk_out));
endmodule : plcs_core_assertions
bind plcs_core plcs_core_assertions u_chk (.i_sys_clk, .i_rst_b, .i_main_reset,
	.i_sec_divider_reset, .o_primary_clk_out, .o_shifted_clk_out, .o_divided_clk_out,
	.o_third_rate_clk_out, .o_lock, .o_ref_div_tick);

// *** tb/test_plcs_core.sv ***
// self-checking bench for the loop clock synthesiser control block
`timescale 1ns/100ps
module test_plcs_core
	import plcs_pkg::*;
;
	logic          sys_clk = 1'b0;
	logic          rst_b = 1'b0;
	logic          sel_fab = 1'b0;
	logic          fb_user = 1'b1;
	logic          main_rst = 1'b0;
	logic          sec_rst = 1'b0;
	logic          dyn_mode = 1'b1;
	logic          fb_run = 1'b1;
	plcs_div_cfg_t div_cfg = {8'h01, 8'h01, 8'h02, 8'h02};
	plcs_dyn_t     stat_adj = {4'h1, 4'h4, 1'b0};
	plcs_dyn_t     dyn_req = {4'h1, 4'h2, 1'b0}; // phase+duty fits the shortest period
	plcs_dyn_t     dyn_adj;
	logic          ref_clk, fb_clk, osc_clk, lock, rtick, ftick;
	wire  [3:0]    clks;
	int            num_errors = 0;
	int            tests_run = 0;
	int            cyc = 0;
	int            per, hi, n;
	plcs_fabric_model fab (.i_sys_clk(sys_clk), .i_fb_run(fb_run), .i_dyn_req(dyn_req),
		.o_ref_clk(ref_clk), .o_fb_clk(fb_clk), .o_osc_clk(osc_clk), .o_dyn_adj(dyn_adj));
	plcs_core dut (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_ref_clk_pin(ref_clk),
		.i_ref_clk_fabric(osc_clk), .i_ref_sel_fabric(sel_fab), .i_feedback_clk_in(fb_clk),
		.i_fb_sel_user(fb_user), .i_osc_clk(osc_clk), .i_main_reset(main_rst),
		.i_sec_divider_reset(sec_rst), .i_div_cfg(div_cfg), .i_dyn_mode(dyn_mode),
		.i_static_adj(stat_adj), .i_dyn_adj(dyn_adj), .o_primary_clk_out(clks[0]),
		.o_shifted_clk_out(clks[3]), .o_divided_clk_out(clks[1]),
		.o_third_rate_clk_out(clks[2]), .o_lock(lock), .o_ref_div_tick(rtick),
		.o_fb_div_tick(ftick));
	// compare a count or a level
	task chk_num(input int got, input int exp, input string msg);
		tests_run++;
		if (got != exp) begin
			num_errors++;
			$display("BAD %0t %s got %0d", $time, msg, got);
		end
	endtask : chk_num
	task chk_bit(input logic got, input logic exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk_bit
	// rise-to-rise period and high time of one output clock, on falling edges
	task measure(input int k);
		n = 0;
		while (clks[k] !== 1'b0 && n < 999) begin
			@(negedge sys_clk);
			n++;
		end
		while (clks[k] !== 1'b1 && n < 999) begin
			@(negedge sys_clk);
			n++;
		end
		per = 0;
		hi = 0;
		do begin
			@(negedge sys_clk);
			per++;
			if (clks[k] === 1'b1) hi++;
		end while ((clks[k] !== 1'b1 || hi == per) && per < 999);
	endtask : measure
	// ticks in 64 cycles after a settling gap
	task count_ticks(input logic fb);
		repeat (16) @(posedge sys_clk);
		n = 0;
		repeat (64) begin
			@(negedge sys_clk);
			if ((fb ? ftick : rtick) === 1'b1) n++;
		end
		@(posedge sys_clk);
	endtask : count_ticks
	task print_verdict();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	always #4 sys_clk = ~sys_clk;
	// hang guard, far above the few thousand cycles the tests need
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (int p = 2; p < 5; p++) begin
			// drive on the rising edge; measure leaves us on a falling one
			@(posedge sys_clk);
			div_cfg.post_div <= 8'(p);
			repeat (80) @(posedge sys_clk);
			measure(0);
			chk_num(per, 4 * p, "primary period");
			measure(1);
			chk_num(per, 8 * p, "divided period");
			measure(2);
			chk_num(per, 12 * p, "third period");
			measure(3);
			chk_num(per, 4 * p, "shifted period");
		end
		// high from phase (xor fine) to phase+duty, two cycles per oscillator step
		chk_num(hi, 4, "dynamic duty");
		@(posedge sys_clk);
		dyn_req.fine_delay_adjust <= 1'b1;
		repeat (40) @(posedge sys_clk);
		measure(3);
		chk_num(hi, 6, "fine delay");
		@(posedge sys_clk);
		dyn_mode <= 1'b0;
		repeat (40) @(posedge sys_clk);
		measure(3);
		chk_num(hi, 8, "static duty");
		$display("test outputs done");
		count_ticks(1'b0);
		chk_num(n, 8, "ref ticks");
		div_cfg.ref_div <= 8'h02;
		div_cfg.fb_div <= 8'h02;
		count_ticks(1'b0);
		chk_num(n, 4, "ref ticks div2");
		sel_fab <= 1'b1;
		count_ticks(1'b1);
		chk_num(n, 4, "fb ticks div2");
		// fabric reference is the fast oscillator level: a rise every 2 cycles
		count_ticks(1'b0);
		chk_num(n, 16, "fabric ref ticks");
		fb_user <= 1'b0;
		div_cfg <= {8'h01, 8'h01, 8'h02, 8'h02};
		count_ticks(1'b1);
		chk_num(n, 8, "internal fb ticks");
		sel_fab <= 1'b0;
		fb_user <= 1'b1;
		main_rst <= 1'b1;
		$display("test dividers done");
		repeat (3) @(negedge sys_clk);
		chk_bit(lock, 1'b0, "lock in reset");
		chk_bit(clks[0], 1'b0, "primary in reset");
		@(posedge sys_clk);
		main_rst <= 1'b0;
		repeat (400) @(negedge sys_clk);
		chk_bit(lock, 1'b0, "early lock");
		n = 0;
		while (lock !== 1'b1 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		chk_bit(lock, 1'b1, "no lock");
		@(posedge sys_clk);
		fb_run <= 1'b0;
		sec_rst <= 1'b1;
		measure(0);
		chk_num(per, 8, "primary in sec reset");
		chk_bit(clks[1], 1'b0, "divided in sec reset");
		// two reference ticks with no feedback between them can take ~18 cycles
		repeat (24) @(negedge sys_clk);
		chk_bit(lock, 1'b0, "lock kept without fb");
		$display("test lock done");
		print_verdict();
	end
endmodule : test_plcs_core
